// >>> verilog/irq_src_pkg.sv
// Package: constants and carriers for the interrupt-source block
package irq_src_pkg;

  // ****************************************
  // Register bit positions
  // ****************************************
  localparam int unsigned MAIN_PORT_CHANGE_FLAG = 0;
  localparam int unsigned MAIN_PORT_CHANGE_EN = 3;
  localparam int unsigned MAIN_TIMER_OVERFLOW_EN = 5;
  localparam int unsigned SECOND_PORT_CHANGE_PRIORITY = 0;
  localparam int unsigned SECOND_TIMER_OVERFLOW_PRIORITY = 2;
  localparam int unsigned THIRD_PIN_B_PRIORITY = 6;
  localparam int unsigned THIRD_PIN_C_PRIORITY = 7;

  // ****************************************
  // Widths, rollover values and reset values
  // ****************************************
  localparam int unsigned NUM_PINS = 3;
  localparam int unsigned NUM_CHANGE = 4;
  localparam logic [7:0] LOW_ROLL_FROM = 8'hff;
  localparam logic [7:0] LOW_ROLL_TO = 8'h00;
  localparam logic [15:0] WIDE_ROLL_FROM = 16'hffff;
  localparam logic [15:0] WIDE_ROLL_TO = 16'h0000;
  localparam logic [2:0] PIN_RESET = 3'h0;
  localparam logic [3:0] CHANGE_RESET = 4'h0;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [2:0] pins;
    logic [2:0] polarity;
    logic [2:0] clear;
    logic [2:0] enable;
  } ext_pin_cfg_t;

  typedef struct packed {
    logic sixteen_bit;
    logic [15:0] count;
    logic clear;
    logic enable;
    logic priority_high;
  } timer_in_t;

  typedef struct packed {
    logic [3:0] pins;
    logic [3:0] is_input;
    logic port_access;
    logic clear;
    logic enable;
    logic priority_high;
  } change_in_t;

  typedef struct packed {
    logic high_req;
    logic low_req;
    logic wake;
    logic vector;
  } irq_out_t;

  typedef enum logic [1:0] {
    CPU_RUN = 2'b01,
    CPU_LOW_POWER = 2'b10
  } power_state_t;

endpackage

// >>> verilog/pin_sampler.sv
// Two-stage synchroniser plus previous-sample register for input pins
module pin_sampler #(
  parameter int unsigned WIDTH = 3
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] sample,
  output logic [WIDTH-1:0] previous
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
  } sampler_state_t;

  sampler_state_t state;
  sampler_state_t next_state;

  // ****************************************
  // Sampling
  // ****************************************
  always_comb begin
    next_state = state;
    next_state.meta = pins;
    next_state.sync = state.meta;
    next_state.prev = state.sync; // [R19]
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sample = state.sync;
  assign previous = state.prev;

endmodule

// >>> verilog/irq_sources.sv
// Interrupt sources: external pins, timer overflow, port change
// ****************************************
// Summary of operation
// [R1] Pin edge: polarity 1 rising, 0 falling
// [R2] Selected pin edge sets its flag
// [R3] Cleared enable suppresses pin request
// [R4] Software clears pin flags itself
// [R5] Enabled pin sources wake from low power
// [R6] Wake vectors only with global enable
// [R7] Pin b/c priority from third control
// [R8] Pin a is always high priority
// [R9] 8-bit rollover FF to 00 sets flag
// [R10] 16-bit mode: FFFF to 0000 only
// [R11] Main bit 5 enables timer overflow
// [R12] Second bit 2 sets timer priority
// [R13] Change on pins 7:4 sets flag
// [R14] Main bit 3 enables port change
// [R15] Second bit 0 sets change priority
// [R16] Compare pins with latched port value
// [R17] Output pins excluded from change compare
// [R18] Mismatch keeps flag set until access
// [R19] Edges found by registered clock samples
// [R20] Priority 1 high, 0 low
// ****************************************
module irq_sources (
  input wire logic core_clk,
  input wire logic nrst,
  input irq_src_pkg::ext_pin_cfg_t ext_pin_cfg,
  input wire logic pin_b_priority,
  input wire logic pin_c_priority,
  input irq_src_pkg::timer_in_t timer_in,
  input irq_src_pkg::change_in_t change_in,
  input wire logic global_irq_en,
  input wire logic enter_low_power,
  output logic [2:0] ext_pin_flag,
  output logic timer_overflow_flag,
  output logic port_change_flag,
  output irq_src_pkg::irq_out_t irq_out,
  output logic cpu_sleeping
);

  typedef struct packed {
    logic [2:0] pin_flag;
    logic timer_flag;
    logic change_flag;
    logic [15:0] count_prev;
    logic [3:0] latched;
    logic [2:0] wake_armed;
    irq_src_pkg::power_state_t power;
    irq_src_pkg::irq_out_t out;
  } core_state_t;

  core_state_t state;
  core_state_t next_state;

  logic [2:0] pin_now;
  logic [2:0] pin_prev;
  logic [3:0] chg_now;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  pin_sampler #(.WIDTH(3)) u_ext_sampler (
    .core_clk(core_clk),
    .nrst(nrst),
    .pins(ext_pin_cfg.pins),
    .sample(pin_now),
    .previous(pin_prev)
  );

  pin_sampler #(.WIDTH(4)) u_change_sampler (
    .core_clk(core_clk),
    .nrst(nrst),
    .pins(change_in.pins),
    .sample(chg_now),
    .previous()
  );

  // Edge of the selected polarity on one pin
  function automatic logic edge_seen(input logic now, input logic prev,
                                     input logic rising);
    edge_seen = rising ? (now & ~prev) : (~now & prev); // [R1]
  endfunction

  // Rollover of a counter value from its top to zero
  function automatic logic rolled(input logic [15:0] now,
                                  input logic [15:0] prev,
                                  input logic wide);
    if (wide) begin
      rolled = (prev == irq_src_pkg::WIDE_ROLL_FROM) &&
               (now == irq_src_pkg::WIDE_ROLL_TO); // [R10]
    end else begin
      rolled = (prev[7:0] == irq_src_pkg::LOW_ROLL_FROM) &&
               (now[7:0] == irq_src_pkg::LOW_ROLL_TO); // [R9]
    end
  endfunction

  // ****************************************
  // Next-state logic
  // ****************************************
  logic [2:0] pin_edge;
  logic [3:0] mismatch;
  logic change_hit;
  logic [2:0] pin_req;
  logic timer_req;
  logic change_req;
  logic any_high;
  logic any_low;
  logic wake_now;

  always_comb begin
    next_state = state;
    pin_edge = '0;
    for (int i = 0; i < 3; i++) begin
      pin_edge[i] = edge_seen(pin_now[i], pin_prev[i],
                              ext_pin_cfg.polarity[i]);
    end
    // Set beats clear so an edge in the clearing cycle is kept
    next_state.pin_flag = (state.pin_flag & ~ext_pin_cfg.clear) |
                          pin_edge; // [R2] [R4]

    // Timer counter is on-chip logic on this clock: no synchroniser
    next_state.count_prev = timer_in.count;
    next_state.timer_flag = (state.timer_flag & ~timer_in.clear) |
                            rolled(timer_in.count, state.count_prev,
                                   timer_in.sixteen_bit);

    // Compare only input-configured pins against last port access
    mismatch = (chg_now ^ state.latched) & change_in.is_input; // [R16] [R17]
    change_hit = |mismatch; // [R13]
    // A live mismatch re-sets the flag every cycle until an access
    next_state.change_flag = (state.change_flag & ~change_in.clear) |
                             change_hit; // [R18]
    if (change_in.port_access) begin
      next_state.latched = chg_now; // [R18]
    end

    pin_req = state.pin_flag & ext_pin_cfg.enable; // [R3]
    timer_req = state.timer_flag & timer_in.enable; // [R11]
    change_req = state.change_flag & change_in.enable; // [R14]

    // Pin a has no select bit and is always high
    any_high = pin_req[0] // [R8]
             | (pin_req[1] & pin_b_priority) // [R7] [R20]
             | (pin_req[2] & pin_c_priority) // [R7] [R20]
             | (timer_req & timer_in.priority_high) // [R12] [R20]
             | (change_req & change_in.priority_high); // [R15] [R20]
    any_low = (pin_req[1] & ~pin_b_priority)
            | (pin_req[2] & ~pin_c_priority)
            | (timer_req & ~timer_in.priority_high)
            | (change_req & ~change_in.priority_high);

    next_state.out.high_req = any_high;
    next_state.out.low_req = any_low;

    // Wake needs the enable that stood when low power was entered
    wake_now = |(state.pin_flag & state.wake_armed); // [R5]
    next_state.out.wake = 1'b0;
    next_state.out.vector = 1'b0;
    case (state.power)
      irq_src_pkg::CPU_RUN: begin
        if (enter_low_power) begin
          next_state.power = irq_src_pkg::CPU_LOW_POWER;
          next_state.wake_armed = ext_pin_cfg.enable; // [R5]
        end
      end
      irq_src_pkg::CPU_LOW_POWER: begin
        if (wake_now) begin
          next_state.power = irq_src_pkg::CPU_RUN;
          next_state.out.wake = 1'b1; // [R5]
          next_state.out.vector = global_irq_en; // [R6]
        end
      end
      default: begin
        next_state.power = irq_src_pkg::CPU_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
      state.power <= irq_src_pkg::CPU_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Outputs from flip-flops; cpu_sleeping is decoded from state.power
  // ****************************************
  assign ext_pin_flag = state.pin_flag;
  assign timer_overflow_flag = state.timer_flag;
  assign port_change_flag = state.change_flag;
  assign irq_out = state.out;
  assign cpu_sleeping = (state.power == irq_src_pkg::CPU_LOW_POWER);

endmodule

// >>> dv/irq_sources_chk.sv
// Checker: output timing of the interrupt-source block
module irq_sources_chk (
  input wire logic core_clk,
  input wire logic nrst,
  input irq_src_pkg::ext_pin_cfg_t ext_pin_cfg,
  input wire logic pin_b_priority,
  input irq_src_pkg::timer_in_t timer_in,
  input irq_src_pkg::change_in_t change_in,
  input wire logic [2:0] ext_pin_flag,
  input wire logic timer_overflow_flag,
  input wire logic port_change_flag,
  input irq_src_pkg::irq_out_t irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******
  // Properties
  // ******
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence roll_low_s;
    !timer_in.sixteen_bit && timer_in.count[7:0] == 8'hff
      ##1 !timer_in.sixteen_bit && timer_in.count[7:0] == 8'h00;
  endsequence
  chk_pin_a_high: assert property (
    ext_pin_flag[0] && ext_pin_cfg.enable[0] |=> irq_out.high_req)
    else $error("pin a request lost");
  chk_pin_b_low: assert property (
    ext_pin_flag[1] && ext_pin_cfg.enable[1] && !pin_b_priority
    |=> irq_out.low_req) else $error("pin b low request lost");
  chk_quiet_off: assert property (
    (ext_pin_cfg.enable == 3'h0 && !timer_in.enable && !change_in.enable)[*2]
    |-> !irq_out.high_req && !irq_out.low_req) else $error("request leak");
  chk_roll_low: assert property (
    roll_low_s |=> timer_overflow_flag) else $error("byte roll missed");
  chk_wide_only: assert property (
    $rose(timer_overflow_flag) && timer_in.sixteen_bit
    |-> $past(timer_in.count) == 16'h0000
        && $past(timer_in.count, 2) == 16'hffff) else $error("wide flag");
  chk_timer_prio: assert property (
    timer_overflow_flag && timer_in.enable && timer_in.priority_high
    |=> irq_out.high_req) else $error("timer request lost");
  chk_change_set: assert property (
    $changed(change_in.pins) && change_in.is_input == 4'hf
    |-> ##[1:5] port_change_flag) else $error("change flag missed");
  chk_out_excluded: assert property (
    change_in.is_input == 4'h0 && !port_change_flag
    |=> !port_change_flag) else $error("output pin raised change");
endmodule

bind irq_sources irq_sources_chk irq_sources_chk_inst (.core_clk, .nrst,
  .ext_pin_cfg, .pin_b_priority, .timer_in, .change_in, .ext_pin_flag,
  .timer_overflow_flag, .port_change_flag, .irq_out);

// >>> dv/isr_model.sv
// Partner: service routine that clears external pin flags
module isr_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic serve,
  input wire logic [2:0] flag,
  output logic [2:0] clr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pulse alternates with idle, so one flag never sees two clears
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) clr <= 3'h0;
    else if (serve && clr == 3'h0) clr <= flag;
    else clr <= 3'h0;
  end
endmodule

// >>> dv/irq_sources_test.sv
// Bench: scenarios for the interrupt-source block
module irq_sources_test;
  timeunit 1ns;
  timeprecision 1ps;
  irq_src_pkg::ext_pin_cfg_t pc = '0;
  irq_src_pkg::ext_pin_cfg_t ext_pin_cfg;
  irq_src_pkg::timer_in_t timer_in = '0;
  irq_src_pkg::change_in_t change_in = '0;
  irq_src_pkg::irq_out_t irq_out;
  logic core_clk = 0, nrst = 0, global_irq_en = 0, enter_low_power = 0;
  logic pin_b_priority = 0, pin_c_priority = 0, serve = 0;
  logic timer_overflow_flag, port_change_flag, cpu_sleeping;
  logic [2:0] ext_pin_flag, clr;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  // Pin flag clears come from the service model only
  assign ext_pin_cfg = {pc.pins, pc.polarity, clr, pc.enable};
  irq_sources irq_sources_inst (.core_clk, .nrst, .ext_pin_cfg,
    .pin_b_priority, .pin_c_priority, .timer_in, .change_in, .global_irq_en,
    .enter_low_power, .ext_pin_flag, .timer_overflow_flag, .port_change_flag,
    .irq_out, .cpu_sleeping);
  isr_model isr_model_inst (.core_clk, .nrst, .serve, .flag(ext_pin_flag),
    .clr);
  initial forever #2 core_clk = ~core_clk;
  // ******
  // Helpers
  // ******
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("errors=%0d compared=%0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic step(input logic [15:0] a, input logic [15:0] b);
    timer_in.count = a;
    tick(2);
    timer_in.count = b;
    tick(2);
  endtask
  // ******
  // Scenarios
  // ******
  task automatic pin_edges;
    for (int i = 0; i < 3; i++) begin
      for (int p = 0; p < 2; p++) begin
        pc.polarity[i] = p[0];
        pc.enable = p[0] ? 3'h1 << i : 3'h0;
        pin_b_priority = !p[0];
        pin_c_priority = !p[0];
        pc.pins[i] = !p[0];
        tick(6);
        chk(ext_pin_flag, 0);
        pc.pins[i] = p[0];
        tick(6);
        chk(ext_pin_flag, 1 << i);
        chk({irq_out.high_req, irq_out.low_req}, p ? (i ? 1 : 2) : 0);
        serve = 1;
        tick(4);
        chk(ext_pin_flag, 0);
        serve = 0;
      end
    end
  endtask
  task automatic timer_roll;
    timer_in.enable = 1;
    timer_in.priority_high = 1;
    step(16'h00ff, 16'h0100);
    chk(timer_overflow_flag, 1);
    chk(irq_out.high_req, 1);
    timer_in.priority_high = 0;
    tick(2);
    chk(irq_out.low_req, 1);
    timer_in.enable = 0;
    timer_in.clear = 1;
    tick(1);
    timer_in.clear = 0;
    timer_in.sixteen_bit = 1;
    step(16'h00ff, 16'h0100);
    chk({timer_overflow_flag, irq_out.low_req}, 0);
    step(16'hffff, 16'h0000);
    chk(timer_overflow_flag, 1);
  endtask
  task automatic change_irq;
    change_in.enable = 1;
    change_in.is_input = 4'hf;
    change_in.pins = 4'h8;
    tick(5);
    chk({port_change_flag, irq_out.low_req}, 3);
    change_in.clear = 1;
    tick(1);
    change_in.clear = 0;
    tick(2);
    chk(port_change_flag, 1);
    change_in.port_access = 1;
    tick(1);
    change_in.port_access = 0;
    tick(3);
    change_in.clear = 1;
    tick(1);
    change_in.clear = 0;
    change_in.is_input = 4'h0;
    change_in.pins = 4'h0;
    tick(6);
    chk(port_change_flag, 0);
  endtask
  task automatic wake_up;
    logic seen, vec;
    for (int g = 0; g < 2; g++) begin
      global_irq_en = g[0];
      pc.enable = 3'h1;
      enter_low_power = 1;
      tick(1);
      enter_low_power = 0;
      pc.pins[0] = 0;
      tick(6);
      chk(cpu_sleeping, 1);
      pc.pins[0] = 1;
      seen = 0;
      vec = 0;
      repeat (12) begin
        tick(1);
        if (irq_out.wake === 1'b1) begin
          seen = 1;
          vec = irq_out.vector;
        end
      end
      chk({seen, vec, cpu_sleeping}, {1'b1, g[0], 1'b0});
      serve = 1;
      tick(4);
      serve = 0;
    end
  endtask
  initial begin
    tick(3);
    nrst = 1;
    pin_edges;
    timer_roll;
    change_irq;
    wake_up;
    close_out;
  end
  // Run takes under two hundred cycles; the ceiling only cuts a hang
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      close_out;
    end
  end
endmodule
